// ===== hdl/adc_trig_defines.svh
// Functional notes
// - Select field plus group bit choose trigger.
// - Group one codes 110-011 take generator outputs.
// - Group one codes 010-000 take PWM generators.
// - PWM generator triggers only on motor variants.
// - Group zero 111 uses internal auto-convert counter.
// - Group zero 110 capacitive, 100 Timer5, 101 reserved.
// - Group zero 011 PWM special, 010 Timer3.
// - Group zero 001 uses external interrupt pin.
// - Group zero 000 is manual, software ends sampling without auto-start.
// - Simultaneous bit samples two or four channels.
// - Simultaneous bit zero samples channels in sequence.
// - Twelve-bit mode reads simultaneous bit as zero.
// - Auto-start restarts sampling after each conversion.
// - Without auto-start, software write starts sampling.
// - Sample bit reads one while sampling.
// - Nonmanual trigger clears sample bit, starts conversion.
// - Manual mode: software writes zero to convert; under auto-start the host holds the sample bit.
// - Done flag sets on completion, else zero.
// - Software only clears done; conversion undisturbed.
// - Done flag clears when a conversion starts.
// - Software never clears done under auto-start.
// - Reset bits are zero; unimplemented read zero.
`ifndef ADC_TRIG_DEFINES_SVH
`define ADC_TRIG_DEFINES_SVH

`define CTRL_SEL_MSB     7
`define CTRL_SEL_LSB     5
`define CTRL_GRP_BIT     4
`define CTRL_SIMULTANEOUS_SAMPLE_BIT  3
`define CTRL_AUTO_SAMPLE_START_BIT    2
`define CTRL_SAMPLE_ENABLE_BIT    1
`define CTRL_DONE_BIT    0
`define CTRL_RESET       8'h00

`define CODE_MANUAL      4'h0
`define CODE_AUTO        4'h7

`define CLK_PERIOD_NS    8
`define AUTO_SAMPLE_NS   96
`define CONV_NS          200
`define AUTO_SAMPLE_CYC  ((`AUTO_SAMPLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CONV_CYC         ((`CONV_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== hdl/adc_trig_pkg.sv
package adc_trig_pkg;

  typedef enum logic [1:0]
  {
    ST_HOLD    = 2'b00,
    ST_SAMPLE  = 2'b01,
    ST_CONVERT = 2'b10
  } adc_state_t;

  typedef logic [7:0] ctrl_byte_t;

endpackage

// ===== hdl/adc_trig_if.sv
`timescale 1ns/10ps
`default_nettype none
interface adc_trig_if;
  logic       wr_en;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  logic [3:0] trig_gen_out;
  logic [2:0] pwm_gen_trig;
  logic       pwm_special;
  logic       timer3_cmp;
  logic       timer5_cmp;
  logic       capacitive_measure_unit;
  logic       external_irq_zero;

  modport device
  (
    input  wr_en,
    input  wr_data,
    output rd_data,
    input  trig_gen_out,
    input  pwm_gen_trig,
    input  pwm_special,
    input  timer3_cmp,
    input  timer5_cmp,
    input  capacitive_measure_unit,
    input  external_irq_zero
  );

  modport host
  (
    output wr_en,
    output wr_data,
    input  rd_data,
    output trig_gen_out,
    output pwm_gen_trig,
    output pwm_special,
    output timer3_cmp,
    output timer5_cmp,
    output capacitive_measure_unit,
    output external_irq_zero
  );
endinterface
`default_nettype wire

// ===== hdl/adc_trig_host.sv
`timescale 1ns/10ps
`default_nettype none
`include "adc_trig_defines.svh"
module adc_trig_host
(
  input  wire logic       mclk_i,
  input  wire logic       sys_rst_i,
  adc_trig_if.host        bus,
  input  wire logic       sw_wr_i,
  input  wire logic [7:0] sw_wr_data_i,
  output logic      [7:0] sw_rd_data_o,
  input  wire logic [3:0] trig_gen_out_i,
  input  wire logic [2:0] pwm_gen_trig_i,
  input  wire logic       pwm_special_i,
  input  wire logic       timer3_cmp_i,
  input  wire logic       timer5_cmp_i,
  input  wire logic       capacitive_measure_unit_i,
  input  wire logic       external_irq_zero_i
);

  logic       wr_en_ff;
  logic [7:0] wr_data_ff;
  logic [7:0] rd_data_ff;
  logic [9:0] trig_ff;
  logic       nxt_wr_en;
  logic [7:0] nxt_wr_data;
  logic [9:0] nxt_trig;
  logic [3:0] code;

  always_comb
  begin
    nxt_wr_en   = sw_wr_i;
    nxt_wr_data = sw_wr_data_i;
    code        = {bus.rd_data[`CTRL_GRP_BIT],
                   bus.rd_data[`CTRL_SEL_MSB:`CTRL_SEL_LSB]};
    // Under auto-start the sample bit belongs to hardware
    if (bus.rd_data[`CTRL_AUTO_SAMPLE_START_BIT])
    begin
      nxt_wr_data[`CTRL_SAMPLE_ENABLE_BIT] = bus.rd_data[`CTRL_SAMPLE_ENABLE_BIT];
      nxt_wr_data[`CTRL_DONE_BIT] = 1'b1;
    end
    // Writing zero to sample ends sampling only in manual mode
    if (code != `CODE_MANUAL && !sw_wr_data_i[`CTRL_SAMPLE_ENABLE_BIT])
    begin
      nxt_wr_data[`CTRL_SAMPLE_ENABLE_BIT] = bus.rd_data[`CTRL_SAMPLE_ENABLE_BIT];
    end
    // A one in the done position is a no-op, never a set
    nxt_wr_data[`CTRL_DONE_BIT] = nxt_wr_data[`CTRL_DONE_BIT];
    nxt_trig = {trig_gen_out_i, pwm_gen_trig_i, pwm_special_i,
                timer3_cmp_i, timer5_cmp_i};
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      wr_en_ff   <= 1'b0;
      wr_data_ff <= `CTRL_RESET;
      rd_data_ff <= `CTRL_RESET;
      trig_ff    <= 10'h000;
    end
    else
    begin
      wr_en_ff   <= nxt_wr_en;
      wr_data_ff <= nxt_wr_data;
      rd_data_ff <= bus.rd_data;
      trig_ff    <= nxt_trig;
    end
  end

  // The interrupt pin stays raw here; the device end synchronises it
  assign bus.wr_en                   = wr_en_ff;
  assign bus.wr_data                 = wr_data_ff;
  assign bus.trig_gen_out            = trig_ff[9:6];
  assign bus.pwm_gen_trig            = trig_ff[5:3];
  assign bus.pwm_special             = trig_ff[2];
  assign bus.timer3_cmp              = trig_ff[1];
  assign bus.timer5_cmp              = trig_ff[0];
  assign bus.capacitive_measure_unit = capacitive_measure_unit_i;
  assign bus.external_irq_zero       = external_irq_zero_i;
  assign sw_rd_data_o                = rd_data_ff;

endmodule
`default_nettype wire

// ===== hdl/adc_trig_device.sv
`timescale 1ns/10ps
`default_nettype none
`include "adc_trig_defines.svh"
module adc_trig_device
#(
  parameter logic HAS_MOTOR_PWM = 1'b1
)
(
  input  wire logic       mclk_i,
  input  wire logic       sys_rst_i,
  adc_trig_if.device      bus,
  input  wire logic       twelve_bit_mode_i,
  input  wire logic [1:0] channel_count_i,
  output logic            conv_start_o,
  output logic            conv_done_o,
  output logic            sampling_o,
  output logic      [3:0] chan_mask_o
);

  localparam logic [4:0] AUTO_LAST = 5'(`AUTO_SAMPLE_CYC - 1);
  localparam logic [4:0] CONV_LAST = 5'(`CONV_CYC - 1);

  adc_trig_pkg::adc_state_t state_ff;
  adc_trig_pkg::adc_state_t nxt_state;
  adc_trig_pkg::ctrl_byte_t rd_data_ff;
  adc_trig_pkg::ctrl_byte_t nxt_rd_data;

  logic [2:0]  sel_ff;
  logic        grp_ff;
  logic        simultaneous_sample_ff;
  logic        auto_sample_start_ff;
  logic        done_ff;
  logic [2:0]  nxt_sel;
  logic        nxt_grp;
  logic        nxt_simultaneous_sample;
  logic        nxt_auto_sample_start;
  logic        nxt_done;

  logic        irq_sync1_ff;
  logic        irq_sync2_ff;
  logic [15:0] lvl_prev_ff;
  logic [15:0] lvl;
  logic [15:0] pulse;

  logic [4:0]  cnt_ff;
  logic [4:0]  nxt_cnt;
  logic [1:0]  chan_ff;
  logic [1:0]  nxt_chan;
  logic [3:0]  code;
  logic        fire;
  logic        start_conv;
  logic        conv_end;
  logic        simultaneous_sample_eff;

  logic        conv_start_ff;
  logic        conv_done_ff;
  logic        sampling_ff;
  logic [3:0]  chan_mask_ff;
  logic [3:0]  nxt_chan_mask;

  // Number of channels stepped through, less one
  function automatic logic [1:0] chan_last(input logic [1:0] cc);
    logic [1:0] r;
    r = 2'h0;
    if (cc[1])
    begin
      r = 2'h3;
    end
    else if (cc[0])
    begin
      r = 2'h1;
    end
    return r;
  endfunction

  // Trigger levels by {group, select}; unused codes stay low
  always_comb
  begin
    lvl     = 16'h0000;
    lvl[1]  = irq_sync2_ff;
    lvl[2]  = bus.timer3_cmp;
    lvl[3]  = bus.pwm_special;
    lvl[4]  = bus.timer5_cmp;
    lvl[6]  = bus.capacitive_measure_unit;
    lvl[10:8]  = bus.pwm_gen_trig & {3{HAS_MOTOR_PWM}};
    lvl[14:11] = bus.trig_gen_out;
    // Rising edge only, so a held level fires once and not again until it falls and rises
    pulse = lvl & ~lvl_prev_ff;
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      irq_sync1_ff <= 1'b0;
      irq_sync2_ff <= 1'b0;
      lvl_prev_ff  <= 16'h0000;
    end
    else
    begin
      irq_sync1_ff <= bus.external_irq_zero;
      irq_sync2_ff <= irq_sync1_ff;
      lvl_prev_ff  <= lvl;
    end
  end

  // Control fields
  always_comb
  begin
    nxt_sel    = sel_ff;
    nxt_grp    = grp_ff;
    nxt_simultaneous_sample = simultaneous_sample_ff;
    nxt_auto_sample_start   = auto_sample_start_ff;
    if (bus.wr_en)
    begin
      nxt_sel    = bus.wr_data[`CTRL_SEL_MSB:`CTRL_SEL_LSB];
      nxt_grp    = bus.wr_data[`CTRL_GRP_BIT];
      nxt_simultaneous_sample = bus.wr_data[`CTRL_SIMULTANEOUS_SAMPLE_BIT] & ~twelve_bit_mode_i;
      nxt_auto_sample_start   = bus.wr_data[`CTRL_AUTO_SAMPLE_START_BIT];
    end
  end

  // Sample/hold sequencing
  always_comb
  begin
    code       = {grp_ff, sel_ff};
    nxt_state  = state_ff;
    nxt_cnt    = cnt_ff;
    fire       = 1'b0;
    start_conv = 1'b0;
    conv_end   = 1'b0;
    unique case (state_ff)
      adc_trig_pkg::ST_HOLD:
      begin
        if (auto_sample_start_ff || (bus.wr_en && bus.wr_data[`CTRL_SAMPLE_ENABLE_BIT]))
        begin
          nxt_state = adc_trig_pkg::ST_SAMPLE;
          nxt_cnt   = 5'h00;
        end
      end
      adc_trig_pkg::ST_SAMPLE:
      begin
        if (cnt_ff != AUTO_LAST)
        begin
          nxt_cnt = cnt_ff + 5'h01;
        end
        if (code == `CODE_MANUAL)
        begin
          fire = bus.wr_en && !bus.wr_data[`CTRL_SAMPLE_ENABLE_BIT];
        end
        else if (code == `CODE_AUTO)
        begin
          fire = (cnt_ff == AUTO_LAST);
        end
        else
        begin
          fire = pulse[code];
        end
        if (fire)
        begin
          start_conv = 1'b1;
          nxt_state  = adc_trig_pkg::ST_CONVERT;
          nxt_cnt    = 5'h00;
        end
      end
      adc_trig_pkg::ST_CONVERT:
      begin
        nxt_cnt = cnt_ff + 5'h01;
        if (cnt_ff == CONV_LAST)
        begin
          conv_end = 1'b1;
          nxt_cnt  = 5'h00;
          nxt_state = auto_sample_start_ff ? adc_trig_pkg::ST_SAMPLE
                              : adc_trig_pkg::ST_HOLD;
        end
      end
      default:
      begin
        nxt_state = adc_trig_pkg::ST_HOLD;
        nxt_cnt   = 5'h00;
      end
    endcase
  end

  // Done flag: completion outranks any clear in the same cycle
  always_comb
  begin
    nxt_done = done_ff;
    if (conv_end)
    begin
      nxt_done = 1'b1;
    end
    else if (start_conv)
    begin
      nxt_done = 1'b0;
    end
    else if (bus.wr_en && !bus.wr_data[`CTRL_DONE_BIT])
    begin
      nxt_done = 1'b0;
    end
  end

  // Channel grouping and readback
  always_comb
  begin
    simultaneous_sample_eff = simultaneous_sample_ff & ~twelve_bit_mode_i;
    nxt_chan   = chan_ff;
    if (start_conv && !simultaneous_sample_eff)
    begin
      nxt_chan = (chan_ff >= chan_last(channel_count_i)) ? 2'h0
                 : chan_ff + 2'h1;
    end
    if (simultaneous_sample_eff && channel_count_i[1])
    begin
      nxt_chan_mask = 4'hf;
    end
    else if (simultaneous_sample_eff && channel_count_i[0])
    begin
      nxt_chan_mask = 4'h3;
    end
    else
    begin
      nxt_chan_mask = 4'h1 << nxt_chan;
    end
    nxt_rd_data = {nxt_sel, nxt_grp, nxt_simultaneous_sample & ~twelve_bit_mode_i,
                   nxt_auto_sample_start,
                   nxt_state == adc_trig_pkg::ST_SAMPLE,
                   nxt_done};
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      state_ff      <= adc_trig_pkg::ST_HOLD;
      cnt_ff        <= 5'h00;
      sel_ff        <= 3'h0;
      grp_ff        <= 1'b0;
      simultaneous_sample_ff     <= 1'b0;
      auto_sample_start_ff       <= 1'b0;
      done_ff       <= 1'b0;
      chan_ff       <= 2'h0;
      rd_data_ff    <= `CTRL_RESET;
      conv_start_ff <= 1'b0;
      conv_done_ff  <= 1'b0;
      sampling_ff   <= 1'b0;
      chan_mask_ff  <= 4'h1;
    end
    else
    begin
      state_ff      <= nxt_state;
      cnt_ff        <= nxt_cnt;
      sel_ff        <= nxt_sel;
      grp_ff        <= nxt_grp;
      simultaneous_sample_ff     <= nxt_simultaneous_sample;
      auto_sample_start_ff       <= nxt_auto_sample_start;
      done_ff       <= nxt_done;
      chan_ff       <= nxt_chan;
      rd_data_ff    <= nxt_rd_data;
      conv_start_ff <= start_conv;
      conv_done_ff  <= conv_end;
      sampling_ff   <= (nxt_state == adc_trig_pkg::ST_SAMPLE);
      chan_mask_ff  <= nxt_chan_mask;
    end
  end

  assign bus.rd_data  = rd_data_ff;
  assign conv_start_o = conv_start_ff;
  assign conv_done_o  = conv_done_ff;
  assign sampling_o   = sampling_ff;
  assign chan_mask_o  = chan_mask_ff;

endmodule
`default_nettype wire

// ===== sim/adc_trig_properties.sv
`timescale 1ns/10ps
`default_nettype none
module adc_trig_properties
(
  input wire logic       mclk_i,
  input wire logic       sys_rst_i,
  input wire logic       wr_en,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] rd_data,
  input wire logic [3:0] trig_gen_out,
  input wire logic       timer3_cmp
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  property p_field_load;
    wr_en |=> rd_data[7:4] == $past(wr_data[7:4]);
  endproperty
  a_field_load: assert property (p_field_load)
    else $error("code field not loaded");
  property p_done_clear;
    $fell(rd_data[1]) |-> !rd_data[0];
  endproperty
  a_done_clear: assert property (p_done_clear)
    else $error("done kept at start");
  property p_conv_len;
    $fell(rd_data[1]) |-> ##[25:26] rd_data[0];
  endproperty
  a_conv_len: assert property (p_conv_len)
    else $error("done late");
  property p_restart;
    $fell(rd_data[1]) && rd_data[2] |-> ##[25:26] rd_data[1];
  endproperty
  a_restart: assert property (p_restart)
    else $error("no restart");
  property p_sample_enable_start;
    wr_en && wr_data[1] && rd_data[0] && !rd_data[1] |=> rd_data[1];
  endproperty
  a_sample_enable_start: assert property (p_sample_enable_start)
    else $error("sampling not started");
  property p_manual_end;
    wr_en && wr_data[7:1] == 7'h00 && rd_data[7:4] == 4'h0
      && rd_data[1] |=> !rd_data[1];
  endproperty
  a_manual_end: assert property (p_manual_end)
    else $error("manual end ignored");
  property p_done_hold;
    wr_en && wr_data[0] && !rd_data[0] && rd_data[1] |=> !rd_data[0];
  endproperty
  a_done_hold: assert property (p_done_hold)
    else $error("done set by write");
  property p_gen_out;
    rd_data[7:4] == 4'h7 && rd_data[1] && !wr_en
      && $rose(trig_gen_out[0]) |-> ##[1:2] !rd_data[1];
  endproperty
  a_gen_out: assert property (p_gen_out)
    else $error("generator trigger missed");
  property p_timer3;
    rd_data[7:4] == 4'h4 && rd_data[1] && !wr_en
      && $rose(timer3_cmp) |-> ##[1:2] !rd_data[1];
  endproperty
  a_timer3: assert property (p_timer3)
    else $error("timer trigger missed");
  property p_auto;
    $rose(rd_data[1]) && rd_data[7:4] == 4'he
      |-> rd_data[1] [*8] ##[3:6] !rd_data[1];
  endproperty
  a_auto: assert property (p_auto)
    else $error("auto convert timing");
  property p_reset_zero;
    $fell(sys_rst_i) |-> rd_data == 8'h00;
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("reset value");
endmodule
`default_nettype wire

// ===== sim/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic        mclk_i;
  logic        sys_rst_i;
  logic        sw_wr_i;
  logic [7:0]  sw_wr_data_i;
  logic [7:0]  sw_rd_data_o;
  logic [15:0] src;
  logic        twelve_bit_mode_i;
  logic [1:0]  channel_count_i;
  logic        conv_start_o;
  logic [3:0]  chan_mask_o;
  logic        conv_done_o;
  logic        sampling_o;
  int          n_done;
  logic [31:0] lfsr;
  logic [3:0]  note_q[$];
  int          fail_count;
  int          n_compared;
  adc_trig_if u_adc_trig_if();
  adc_trig_host u_adc_trig_host
  (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .bus(u_adc_trig_if.host),
    .sw_wr_i(sw_wr_i),
    .sw_wr_data_i(sw_wr_data_i),
    .sw_rd_data_o(sw_rd_data_o),
    .trig_gen_out_i(src[14:11]),
    .pwm_gen_trig_i(src[10:8]),
    .pwm_special_i(src[3]),
    .timer3_cmp_i(src[2]),
    .timer5_cmp_i(src[4]),
    .capacitive_measure_unit_i(src[6]),
    .external_irq_zero_i(src[1])
  );
  adc_trig_device u_adc_trig_device
  (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .bus(u_adc_trig_if.device),
    .twelve_bit_mode_i(twelve_bit_mode_i),
    .channel_count_i(channel_count_i),
    .conv_start_o(conv_start_o),
    .conv_done_o(conv_done_o),
    .sampling_o(sampling_o),
    .chan_mask_o(chan_mask_o)
  );
  adc_trig_properties u_adc_trig_properties
  (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .wr_en(u_adc_trig_if.wr_en),
    .wr_data(u_adc_trig_if.wr_data),
    .rd_data(u_adc_trig_if.rd_data),
    .trig_gen_out(u_adc_trig_if.trig_gen_out),
    .timer3_cmp(u_adc_trig_if.timer3_cmp)
  );
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    next_rand = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task automatic wr(input logic [7:0] d);
    tick(1);
    sw_wr_i = 1'b1;
    sw_wr_data_i = d;
    tick(1);
    sw_wr_i = 1'b0;
  endtask
  task automatic rd(input logic [7:0] exp);
    tick(5);
    cmp8(sw_rd_data_o, exp);
  endtask
  // Trailing wait lets the synchronised pin edge land before the next write
  task automatic pulse(input logic [15:0] m);
    tick(3);
    src = m;
    tick(3);
    src = 16'h0000;
    tick(6);
  endtask
  // Each start pops the code that was armed; a spare start finds no note
  // Notes hold the code as {group, select}, the readback as {select, group}
  always @(posedge mclk_i)
  begin
    if (conv_done_o === 1'b1)
      n_done++;
    if (conv_start_o === 1'b1)
    begin
      cmp8({7'h00, sampling_o}, 8'h00);
      if (note_q.size() == 0)
        cmp8(8'hff, 8'h00);
      else
        cmp8({4'h0, sw_rd_data_o[4], sw_rd_data_o[7:5]},
             {4'h0, note_q.pop_front()});
    end
  end
  initial
  begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
  end
  // Whole sequence needs about 1060 cycles
  initial
  begin
    #200000;
    fail_count++;
    report_and_stop();
  end
  initial
  begin
    sys_rst_i = 1'b1;
    sw_wr_i = 1'b0;
    sw_wr_data_i = 8'h00;
    src = 16'h0000;
    twelve_bit_mode_i = 1'b1;
    channel_count_i = 2'b10;
    lfsr = 32'h28f8f799;
    fail_count = 0;
    n_compared = 0;
    n_done = 0;
    tick(8);
    sys_rst_i = 1'b0;
    rd(8'h00);
    wr(8'h08);
    rd(8'h00);
    twelve_bit_mode_i = 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      channel_count_i = (i == 1) ? 2'b01 : 2'b10;
      wr({4'h0, 1'(i < 2), 3'b010});
      note_q.push_back(4'h0);
      wr({4'h0, 1'(i < 2), 3'b000});
      tick(30);
      if (i < 2)
        cmp8({4'h0, chan_mask_o}, (i == 0) ? 8'h0f : 8'h03);
      else
        cmp8(8'($countones(chan_mask_o)), 8'h01);
    end
    rd(8'h01);
    wr(8'h00);
    rd(8'h00);
    wr(8'h01);
    rd(8'h00);
    for (int c = 1; c < 15; c++)
    begin
      if (c == 5 || c == 7)
        continue;
      wr({3'(c), 1'(c >> 3), 4'h2});
      lfsr = next_rand(lfsr);
      pulse(16'h0001 << (4'(c) ^ (lfsr[3:0] | 4'h1)));
      note_q.push_back(4'(c));
      pulse(16'h0001 << c);
      tick(30);
    end
    wr(8'ha2);
    wr(8'ha3);
    pulse(16'hffff);
    wr(8'hf2);
    pulse(16'hffff);
    wr(8'h02);
    note_q.push_back(4'h0);
    wr(8'h00);
    tick(30);
    note_q.push_back(4'h7);
    wr(8'he2);
    tick(50);
    wr(8'h44);
    for (int k = 0; k < 2; k++)
    begin
      note_q.push_back(4'h2);
      pulse(16'h0004);
      tick(30);
    end
    rd(8'h47);
    wr(8'h06);
    rd(8'h07);
    // Auto-start makes the host keep sample and done, so drop it first
    wr(8'h02);
    note_q.push_back(4'h0);
    wr(8'h00);
    tick(30);
    cmp8(8'(note_q.size()), 8'h00);
    cmp8(8'(n_done), 8'h14);
    report_and_stop();
  end
endmodule
`default_nettype wire
